// >>> inc/mex_pkg.sv
// Purpose: Shared constants for the 4-bit core instruction execution block.
// Assumes: 10-bit instruction words, 4-bit data, APB register access.
// Notes: Register offsets are byte addresses of aligned 32-bit words.
package mex_pkg;
    localparam int unsigned INSTR_W = 10;
    localparam int unsigned NIB_W = 4;
    localparam int unsigned NUM_PORTS = 5;
    localparam int unsigned PC_W = 12;
    // ************************************************************
    // Instruction encodings.
    // ************************************************************
    localparam logic [7:0] LOAD_Z_TOP = 8'h12;
    localparam logic [9:0] NOP_CODE = 10'h000;
    localparam logic [9:0] PORT_OUT_BASE = 10'h220;
    localparam logic [9:0] OR_MEM_CODE = 10'h019;
    // ************************************************************
    // Register map.
    // ************************************************************
    localparam logic [7:0] ACC_OFS = 8'h00;
    localparam logic [7:0] STATE_OFS = 8'h04;
    localparam logic [7:0] PORTS_OFS = 8'h08;
    localparam logic [7:0] CTRL_OFS = 8'h0c;
    localparam int unsigned CTRL_EXEC_BIT = 0;
    localparam int unsigned CTRL_CARRY_BIT = 1;
    localparam int unsigned STATE_Z_POS = 12;
    localparam int unsigned STATE_CARRY_POS = 14;
    // ************************************************************
    // Reset values.
    // ************************************************************
    localparam logic [3:0] ACC_RST = 4'h0;
    localparam logic [3:0] PORT_RST = 4'h0;
    localparam logic [1:0] Z_RST = 2'h0;
    localparam logic [11:0] PC_RST = 12'h000;
    localparam logic CARRY_RST = 1'b0;
    localparam logic CTRL_EXEC_RST = 1'b1;
endpackage

// >>> inc/mex_dec_if.sv
// Purpose: Carries an instruction word to the decoder and its decoded class back.
// Assumes: Decoding is purely combinational.
// Notes: One-hot class flags; port_sel is one-hot over the five output ports.
`timescale 1ns/1ps
`default_nettype none
interface mex_dec_if;
    logic [9:0] instr;
    logic is_load_z;
    logic is_nop;
    logic is_or_mem;
    logic [4:0] port_sel;
    modport dec (
        input instr,
        output is_load_z,
        output is_nop,
        output is_or_mem,
        output port_sel
    );
    modport exe (
        output instr,
        input is_load_z,
        input is_nop,
        input is_or_mem,
        input port_sel
    );
endinterface
`default_nettype wire

// >>> hdl/mex_decoder.sv
// Purpose: Classifies a 10-bit instruction word for the execution block.
// Assumes: Words outside this block's group decode to no class at all.
// Notes: Purely combinational.
`timescale 1ns/1ps
`default_nettype none
module mex_decoder (
    // Instruction in, class out.
    mex_dec_if.dec dec
);
    function automatic logic is_port(input logic [9:0] w, input logic [9:0] k);
        is_port = (w == 10'(mex_pkg::PORT_OUT_BASE + k));
    endfunction

    always_comb begin
        dec.is_load_z = (dec.instr[9:2] == mex_pkg::LOAD_Z_TOP);
        dec.is_nop = (dec.instr == mex_pkg::NOP_CODE);
        dec.is_or_mem = (dec.instr == mex_pkg::OR_MEM_CODE);
        for (int k = 0; k < 5; k++) begin
            dec.port_sel[k] = is_port(dec.instr, 10'(k));
        end
    end
endmodule
`default_nettype wire

// >>> hdl/mex_exec.sv
// Purpose: Executes the Z load, no-op, port output and OR-with-memory instructions.
// Assumes: Instruction, memory nibble and strobe come from logic on clock_i.
// Notes: Registers reached over APB; every executed word advances the program counter.
// How it works
// - A word whose top eight bits are 00010010 loads its low two bits into Z in one cycle.
// - The no-op only advances the program counter and leaves all else unchanged.
// - The port-0 output word copies the accumulator to port 0 in one cycle, carry untouched.
// - The port-1 output word copies the accumulator to port 1 in one cycle, carry untouched.
// - The port-2 output word copies the accumulator to port 2 in one cycle, carry untouched.
// - The port-3 output word copies the accumulator to port 3 in one cycle, carry untouched.
// - The port-4 output word copies the accumulator to port 4 in one cycle, carry untouched.
// - The OR word ORs the accumulator with the addressed memory nibble into the accumulator.
`timescale 1ns/1ps
`default_nettype none
module mex_exec #(
    parameter int unsigned PC_W = mex_pkg::PC_W
) (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Instruction stream.
    input wire logic instr_valid_i,
    input wire logic [9:0] instr_i,
    input wire logic [3:0] mem_nibble_i,
    // Output port pins.
    output logic [3:0] port0_o,
    output logic [3:0] port1_o,
    output logic [3:0] port2_o,
    output logic [3:0] port3_o,
    output logic [3:0] port4_o,
    // APB slave.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o
);
    mex_dec_if dec_if ();
    logic [3:0] acc_q;
    logic [1:0] z_q;
    logic [PC_W-1:0] program_counter_q;
    logic carry_flag_q;
    logic exec_en_q;
    logic [3:0] port_q [5];
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic exec;
    logic bus_wr;
    logic acc_wr;

    // ************************************************************
    // Decode.
    // ************************************************************
    assign dec_if.instr = instr_i;

    mex_decoder mex_decoder_inst (
        .dec(dec_if.dec)
    );

    assign exec = instr_valid_i & exec_en_q;
    assign bus_wr = psel_i & penable_i & pready_q & pwrite_i;
    assign acc_wr = bus_wr & (paddr_i == mex_pkg::ACC_OFS);

    // ************************************************************
    // Execution state.
    // ************************************************************
    // Counter advance only.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            program_counter_q <= PC_W'(mex_pkg::PC_RST);
        end else if (exec) begin
            program_counter_q <= program_counter_q + PC_W'(1);
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            z_q <= mex_pkg::Z_RST;
        end else if (exec && dec_if.is_load_z) begin
            z_q <= instr_i[1:0];
        end
    end

    // A bus write to the accumulator wins over an OR in the same cycle, so software
    // can always force a known value.
    // Accumulator OR memory.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_q <= mex_pkg::ACC_RST;
        end else if (acc_wr) begin
            acc_q <= pwdata_i[3:0];
        end else if (exec && dec_if.is_or_mem) begin
            acc_q <= acc_q | mem_nibble_i;
        end
    end

    // Carry is only touched by software here; none of these instructions change it.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            carry_flag_q <= mex_pkg::CARRY_RST;
            exec_en_q <= mex_pkg::CTRL_EXEC_RST;
        end else if (bus_wr && paddr_i == mex_pkg::CTRL_OFS) begin
            carry_flag_q <= pwdata_i[mex_pkg::CTRL_CARRY_BIT];
            exec_en_q <= pwdata_i[mex_pkg::CTRL_EXEC_BIT];
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int k = 0; k < 5; k++) begin
                port_q[k] <= mex_pkg::PORT_RST;
            end
        end else if (exec) begin
            for (int k = 0; k < 5; k++) begin
                if (dec_if.port_sel[k]) begin
                    port_q[k] <= acc_q;
                end
            end
        end
    end

    assign port0_o = port_q[0];
    assign port1_o = port_q[1];
    assign port2_o = port_q[2];
    assign port3_o = port_q[3];
    assign port4_o = port_q[4];

    // ************************************************************
    // APB slave.
    // ************************************************************
    // One wait state keeps every bus output straight from a flip-flop.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= psel_i & penable_i & ~pready_q;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            if (psel_i && penable_i && !pready_q) begin
                case (paddr_i)
                    mex_pkg::ACC_OFS: begin
                        prdata_q <= {28'h000_0000, acc_q};
                    end
                    mex_pkg::STATE_OFS: begin
                        prdata_q[PC_W-1:0] <= program_counter_q;
                        prdata_q[mex_pkg::STATE_Z_POS +: 2] <= z_q;
                        prdata_q[mex_pkg::STATE_CARRY_POS] <= carry_flag_q;
                    end
                    mex_pkg::PORTS_OFS: begin
                        prdata_q <= {12'h000, port_q[4], port_q[3], port_q[2],
                            port_q[1], port_q[0]};
                    end
                    mex_pkg::CTRL_OFS: begin
                        prdata_q[mex_pkg::CTRL_EXEC_BIT] <= exec_en_q;
                        prdata_q[mex_pkg::CTRL_CARRY_BIT] <= carry_flag_q;
                    end
                    default: begin
                        pslverr_q <= 1'b1;
                    end
                endcase
            end
        end
    end

    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign prdata_o = prdata_q;

    // ************************************************************
    // Checks.
    // ************************************************************
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence nop_issue_s;
        exec && dec_if.is_nop;
    endsequence

    sequence nop_effect_s;
        program_counter_q == $past(program_counter_q) + PC_W'(1)
            && $stable(acc_q) && $stable(z_q) && $stable(carry_flag_q);
    endsequence

    z_load_a: assert property (exec && dec_if.is_load_z |=> z_q == $past(instr_i[1:0]))
        else $error("Z did not take the immediate bits.");
    nop_only_pc_a: assert property (nop_issue_s |=> nop_effect_s)
        else $error("No-op changed more than the program counter.");
    port_zero_a: assert property (exec && instr_i == 10'h220 |=>
        port0_o == $past(acc_q) && $stable(carry_flag_q))
        else $error("Port 0 did not take the accumulator.");
    port_one_a: assert property (exec && instr_i == 10'h221 |=>
        port1_o == $past(acc_q) && $stable(carry_flag_q))
        else $error("Port 1 did not take the accumulator.");
    port_two_a: assert property (exec && instr_i == 10'h222 |=>
        port2_o == $past(acc_q) && $stable(carry_flag_q) && $stable(acc_q))
        else $error("Port 2 did not take the accumulator.");
    port_three_a: assert property (exec && instr_i == 10'h223 |=>
        port3_o == $past(acc_q) && $stable(carry_flag_q))
        else $error("Port 3 did not take the accumulator.");
    port_four_a: assert property (exec && instr_i == 10'h224 |=>
        port4_o == $past(acc_q) && $stable(carry_flag_q))
        else $error("Port 4 did not take the accumulator.");
    or_result_a: assert property (exec && dec_if.is_or_mem && !acc_wr |=>
        acc_q == ($past(acc_q) | $past(mem_nibble_i)) && $stable(carry_flag_q))
        else $error("OR result wrong in accumulator.");
    port_hold_a: assert property (!(exec && (|dec_if.port_sel)) |=>
        $stable(port0_o) && $stable(port1_o) && $stable(port2_o)
        && $stable(port3_o) && $stable(port4_o))
        else $error("A port changed without an output word.");
    bus_wait_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("APB answer missing after one wait state.");
endmodule
`default_nettype wire

// >>> sim/mex_pin_model.sv
// Purpose: Stands for the board that watches the five output port pins.
// Assumes: Port pins are plain driven outputs, no pull-ups involved.
// Notes: Packs the pins as port 0 in the low nibble up to port 4 on top.
`timescale 1ns/1ps
`default_nettype none
module mex_pin_model (
    // Port pins seen from outside.
    input wire logic [3:0] port0_i,
    input wire logic [3:0] port1_i,
    input wire logic [3:0] port2_i,
    input wire logic [3:0] port3_i,
    input wire logic [3:0] port4_i,
    // Packed view for the bench.
    output logic [19:0] pins_o
);
    assign pins_o = {port4_i, port3_i, port2_i, port1_i, port0_i};
endmodule
`default_nettype wire

// >>> sim/mcu4_misc_io_instr_exec_bench.sv
// Purpose: Self-checking bench for the Z load, no-op, port output and OR words.
// Assumes: APB answers whenever pready rises; an instruction shows one edge later.
// Notes: The accumulator is preset over APB before every row, carry is held at one.
`timescale 1ns/1ps
`default_nettype none
module mcu4_misc_io_instr_exec_bench;
    typedef struct packed {logic [3:0] a; logic [9:0] op; logic [3:0] m;} mex_row_t;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic instr_valid_i = 1'b0;
    logic [9:0] instr_i = 10'h000;
    logic [3:0] mem_nibble_i = 4'h0;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic pready_o, pslverr_o, err;
    logic [3:0] port0_o, port1_o, port2_o, port3_o, port4_o, exp_a;
    logic [19:0] pins, exp_p;
    logic [1:0] exp_z;
    logic [11:0] exp_count;
    int num_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    mex_row_t rows [9] = '{'{4'h5, 10'h220, 4'h0}, '{4'h6, 10'h221, 4'h0},
        '{4'h9, 10'h222, 4'h0}, '{4'ha, 10'h223, 4'h0}, '{4'hc, 10'h224, 4'h0},
        '{4'h3, 10'h019, 4'h8}, '{4'h0, 10'h04b, 4'h0}, '{4'h7, 10'h000, 4'hf},
        '{4'h2, 10'h049, 4'h0}};

    mex_exec mex_exec_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .instr_valid_i(instr_valid_i), .instr_i(instr_i), .mem_nibble_i(mem_nibble_i),
        .port0_o(port0_o), .port1_o(port1_o), .port2_o(port2_o), .port3_o(port3_o),
        .port4_o(port4_o), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o));
    mex_pin_model mex_pin_model_inst (.port0_i(port0_o), .port1_i(port1_o),
        .port2_i(port2_o), .port3_i(port3_o), .port4_i(port4_o), .pins_o(pins));

    initial begin
        forever #5 clock_i = ~clock_i;
    end

    task summarize;
        $display("errors %0d tests %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // The ceiling is generous; the whole run needs a few hundred cycles.
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            num_errors++;
            summarize();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // An idle cycle after each transfer keeps two drives off one time step.
    // Only the bench timeout ends a wait for pready.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        @(posedge clock_i);
        while (pready_o !== 1'b1) begin
            @(posedge clock_i);
        end
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clock_i);
    endtask

    task step(input logic [9:0] op, input logic [3:0] m);
        exp_count = exp_count + 12'h001;
        if (op[9:3] == mex_pkg::PORT_OUT_BASE[9:3] && op[2:0] < 3'h5)
            exp_p[op[2:0]*4 +: 4] = exp_a;
        if (op[9:2] == mex_pkg::LOAD_Z_TOP) exp_z = op[1:0];
        if (op == mex_pkg::OR_MEM_CODE) exp_a = exp_a | m;
    endtask

    task check_all(input logic carry);
        @(negedge clock_i);
        chk({12'h0, pins}, {12'h0, exp_p}, "ports");
        @(posedge clock_i);
        apb(1'b0, mex_pkg::ACC_OFS, 32'h0);
        chk(rd, {28'h0, exp_a}, "acc");
        apb(1'b0, mex_pkg::STATE_OFS, 32'h0);
        chk(rd, {17'h0, carry, exp_z, exp_count}, "state");
    endtask

    initial begin
        exp_p = 20'h0;
        exp_a = 4'h0;
        exp_z = 2'h0;
        exp_count = 12'h000;
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        check_all(1'b0);
        apb(1'b1, mex_pkg::CTRL_OFS, 32'h3);
        foreach (rows[i]) begin
            apb(1'b1, mex_pkg::ACC_OFS, {28'h0, rows[i].a});
            exp_a = rows[i].a;
            instr_valid_i <= 1'b1;
            instr_i <= rows[i].op;
            mem_nibble_i <= rows[i].m;
            @(posedge clock_i);
            instr_valid_i <= 1'b0;
            step(rows[i].op, rows[i].m);
            check_all(1'b1);
            $display("row %0d done", i);
        end
        // Back to back: port word keeps the old value, then OR updates it.
        apb(1'b1, mex_pkg::ACC_OFS, 32'he);
        exp_a = 4'he;
        instr_valid_i <= 1'b1;
        instr_i <= 10'h224;
        @(posedge clock_i);
        instr_i <= 10'h019;
        mem_nibble_i <= 4'h1;
        @(posedge clock_i);
        instr_valid_i <= 1'b0;
        step(10'h224, 4'h0);
        step(10'h019, 4'h1);
        check_all(1'b1);
        $display("back to back done");
        apb(1'b1, 8'h10, 32'hffffffff);
        chk({31'h0, err}, 32'h1, "unmapped write");
        apb(1'b0, 8'h10, 32'h0);
        chk({rd[30:0], err}, 32'h1, "unmapped read");
        $display("unmapped done");
        apb(1'b0, mex_pkg::PORTS_OFS, 32'h0);
        chk(rd, {12'h0, exp_p}, "port register");
        apb(1'b1, mex_pkg::CTRL_OFS, 32'h0);
        apb(1'b0, mex_pkg::CTRL_OFS, 32'h0);
        chk(rd, 32'h0, "control off");
        instr_valid_i <= 1'b1;
        instr_i <= 10'h220;
        @(posedge clock_i);
        instr_valid_i <= 1'b0;
        check_all(1'b0);
        $display("execute off done");
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        exp_p = 20'h0;
        exp_a = 4'h0;
        exp_z = 2'h0;
        exp_count = 12'h000;
        check_all(1'b0);
        $display("second reset done");
        summarize();
    end
endmodule
`default_nettype wire
